/* File: logic/ppfm_regs.svh */
// Constants for the port pin function multiplexer: write codes, reset values, pin masks.
// Assumes inclusion by the modules that name these constants, ppfm_port_cfg and ppfm_top.
`ifndef PPFM_REGS_SVH
`define PPFM_REGS_SVH
`define PPFM_NUM_PORTS 11
`define PPFM_PORT_A 4'h0
`define PPFM_PORT_E 4'h4
`define PPFM_PORT_F 4'h5
`define PPFM_PORT_G 4'h6
`define PPFM_PORT_J 4'h9
`define PPFM_PORT_K 4'ha
// Setting selectors on the write port.
`define PPFM_SEL_CR  3'h0
`define PPFM_SEL_FR1 3'h1
`define PPFM_SEL_FR2 3'h2
`define PPFM_SEL_FR3 3'h3
`define PPFM_SEL_OD  3'h4
`define PPFM_SEL_PUP 3'h5
`define PPFM_SEL_PDN 3'h6
`define PPFM_SEL_IE  3'h7
// Reset values of port E, the only port leaving reset with nonzero settings.
`define PPFM_E_RST_IE  8'hc3
`define PPFM_E_RST_CR  8'h82
`define PPFM_E_RST_PUP 8'h82
`define PPFM_E_RST_PDN 8'h41
`define PPFM_E_RST_FR2 8'hc3
// Implemented-bit masks per port (A..K) for the basic settings and the three function registers.
`define PPFM_MASK_BASIC 88'h03_3f_7f_3f_01_03_ff_ff_ff_ff_ff
`define PPFM_MASK_FR1   88'h03_3f_7f_3f_01_02_ff_ff_ff_ff_ff
`define PPFM_MASK_FR2   88'h00_34_45_2d_01_00_fc_00_00_00_00
`define PPFM_MASK_FR3   88'h00_00_44_24_00_00_08_00_00_00_00
// Port J bit 5 is input only: no output control, drain or pulls there.
`define PPFM_MASK_J_OUT 8'h1f
`endif

/* File: logic/ppfm_pkg.sv */
// Types shared by the port pin function multiplexer modules.
// Assumes ppfm_regs.svh is on the include path.
`default_nettype none
package ppfm_pkg;
	// Full configuration of one 8-bit port.
	typedef struct packed {
		logic [7:0] output_control_bits;
		logic [7:0] function_select_1;
		logic [7:0] function_select_2;
		logic [7:0] function_select_3;
		logic [7:0] open_drain_bits;
		logic [7:0] pull_up_bits;
		logic [7:0] pull_down_bits;
		logic [7:0] input_enable_bits;
	} ppfm_port_cfg_t;
	// Resolved drive of one port toward its pads.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
		logic [7:0] in_en;
	} ppfm_pad_t;
	// Function chosen for a pin after priority resolution.
	typedef enum logic [3:0] {
		PPFM_FN_GPIO = 4'h1,
		PPFM_FN_F1   = 4'h2,
		PPFM_FN_F2   = 4'h4,
		PPFM_FN_F3   = 4'h8
	} ppfm_fn_t;
endpackage
`default_nettype wire

/* File: logic/ppfm_port_cfg.sv */
// One port's setting registers, with write masking of nonexistent bits.
// Assumes a synchronous write strobe from the core configuration logic.
`include "ppfm_regs.svh"
`default_nettype none
module ppfm_port_cfg
	import ppfm_pkg::*;
#(
	parameter logic [3:0] PORT_ID = 4'h0
) (
	input  wire logic            clk_sys,
	input  wire logic            rst_n,
	input  wire logic            wr_en,
	input  wire logic [2:0]      wr_sel,
	input  wire logic [7:0]      wr_data,
	output var  ppfm_port_cfg_t  cfg
);
	// Masks selecting the bits that physically exist on this port.
	localparam logic [7:0] M_B  = 8'((`PPFM_MASK_BASIC >> (8 * PORT_ID)) & 88'hff);
	localparam logic [7:0] M_F1 = 8'((`PPFM_MASK_FR1 >> (8 * PORT_ID)) & 88'hff);
	localparam logic [7:0] M_F2 = 8'((`PPFM_MASK_FR2 >> (8 * PORT_ID)) & 88'hff);
	localparam logic [7:0] M_F3 = 8'((`PPFM_MASK_FR3 >> (8 * PORT_ID)) & 88'hff);
	localparam logic [7:0] M_O  = (PORT_ID == `PPFM_PORT_J) ? (M_B & `PPFM_MASK_J_OUT) : M_B;
	localparam bit IS_E = (PORT_ID == `PPFM_PORT_E);

	ppfm_port_cfg_t cfg_r;   // Stored settings.
	ppfm_port_cfg_t cfg_nxt; // Next settings.

	// Elaboration guard: only ports A to K have masks and reset values.
	if (PORT_ID > 4'ha) begin : g_port_id_chk
		$error("ppfm_port_cfg: PORT_ID out of range.");
	end

	// Writes land only in existing bits; others are written as 0, except that port E reset sets absent FR2 bits 0 and 1.
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_en) begin
			case (wr_sel)
				`PPFM_SEL_CR:  cfg_nxt.output_control_bits = wr_data & M_O;
				`PPFM_SEL_FR1: cfg_nxt.function_select_1   = wr_data & M_F1;
				`PPFM_SEL_FR2: cfg_nxt.function_select_2   = wr_data & M_F2;
				`PPFM_SEL_FR3: cfg_nxt.function_select_3   = wr_data & M_F3;
				`PPFM_SEL_OD:  cfg_nxt.open_drain_bits     = wr_data & M_O;
				`PPFM_SEL_PUP: cfg_nxt.pull_up_bits        = wr_data & M_O;
				`PPFM_SEL_PDN: cfg_nxt.pull_down_bits      = wr_data & M_O;
				`PPFM_SEL_IE:  cfg_nxt.input_enable_bits   = wr_data & M_B;
				default:       cfg_nxt = cfg_r;
			endcase
		end
	end

	// Reset leaves all settings 0 except the debug pins on port E.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= '0;
			if (IS_E) begin
				cfg_r.input_enable_bits   <= `PPFM_E_RST_IE;
				cfg_r.output_control_bits <= `PPFM_E_RST_CR;
				cfg_r.pull_up_bits        <= `PPFM_E_RST_PUP;
				cfg_r.pull_down_bits      <= `PPFM_E_RST_PDN;
				cfg_r.function_select_2   <= `PPFM_E_RST_FR2;
			end
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign cfg = cfg_r;
endmodule // ppfm_port_cfg
`default_nettype wire

/* File: logic/ppfm_top.sv */
// Pin function multiplexer for ports A to K: settings, pad drive and input routing.
// Assumes pad inputs synchronous to clk_sys and a testbench resolving pad wires.
`include "ppfm_regs.svh"
`default_nettype none
module ppfm_top
	import ppfm_pkg::*;
#(
	parameter int NUM_PORTS = `PPFM_NUM_PORTS
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire logic                    cfg_wr_en,
	input  wire logic [3:0]              cfg_wr_port,
	input  wire logic [2:0]              cfg_wr_sel,
	input  wire logic [7:0]              cfg_wr_data,
	input  wire logic [3:0]              cfg_rd_port,
	input  wire logic [2:0]              cfg_rd_sel,
	input  wire logic                    stop_mode,
	input  wire logic [NUM_PORTS*8-1:0]  port_data,
	input  wire logic [NUM_PORTS*8-1:0]  periph_out,
	input  wire logic [NUM_PORTS*8-1:0]  periph_oe,
	input  wire logic [39:0]             lcd_segment_out,
	input  wire logic [NUM_PORTS*8-1:0]  pad_in,
	output logic      [7:0]              cfg_rd_data,
	output logic      [NUM_PORTS*8-1:0]  pad_out,
	output logic      [NUM_PORTS*8-1:0]  pad_oe,
	output logic      [NUM_PORTS*8-1:0]  pad_pull_up,
	output logic      [NUM_PORTS*8-1:0]  pad_pull_down,
	output logic      [NUM_PORTS*8-1:0]  port_in,
	output logic      [NUM_PORTS*8-1:0]  periph_in,
	output logic      [1:0]              analog_input,
	output logic      [1:0]              low_voltage_detect_in,
	output logic      [3:0]              ext_interrupt_in,
	output logic                         timer_capture_in,
	output logic                         external_clock_in
);
	localparam int NP = `PPFM_NUM_PORTS;
	// NP mirrors the shared port count; NUM_PORTS sizes the pin vectors and is checked against it.

	ppfm_port_cfg_t cfg_a [NP]; // Settings of each port.
	ppfm_pad_t      pad_nxt [NP]; // Resolved pad drive per port.
	logic [7:0]     in_nxt [NP];  // Gated pad input per port.
	logic [7:0]     rd_nxt;       // Readback mux.
	logic [3:0]     irq_nxt;      // Interrupt inputs.
	logic [1:0]     ain_nxt;      // Analog pass enables.
	logic [1:0]     lvd_nxt;      // Low-voltage pass enables.
	logic           cap_nxt;      // Timer capture input.
	logic           xclk_nxt;     // External clock input.
	// Flattened per-pin views, indexed port*8+bit, that feed the output registers.
	logic [NUM_PORTS*8-1:0] out_flat; // Pad output level per pin.
	logic [NUM_PORTS*8-1:0] oe_flat;  // Pad drive enable per pin.
	logic [NUM_PORTS*8-1:0] pu_flat;  // Pull-up request per pin.
	logic [NUM_PORTS*8-1:0] pd_flat;  // Pull-down request per pin.
	logic [NUM_PORTS*8-1:0] in_flat;  // Input-enabled pad level per pin.
	logic [NUM_PORTS*8-1:0] pin_flat; // Pad level handed to a selected peripheral.

	// Elaboration guard: the pin map, masks and fixed routing assume 11 ports.
	if (NUM_PORTS != `PPFM_NUM_PORTS) begin : g_num_ports_chk
		$error("ppfm_top: NUM_PORTS must be 11.");
	end

	// One setting bank per port and one resolver per pin.
	// Each pin resolves its own function, so a bad setting on one pin never
	// disturbs its neighbours; the cost is one small decoder per pin.
	for (genvar p = 0; p < NP; p++) begin : g_port
		ppfm_port_cfg #(.PORT_ID(4'(p))) u_cfg (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.wr_en   (cfg_wr_en && (cfg_wr_port == 4'(p))),
			.wr_sel  (cfg_wr_sel),
			.wr_data (cfg_wr_data),
			.cfg     (cfg_a[p])
		);
		for (genvar b = 0; b < 8; b++) begin : g_bit
			ppfm_fn_t fn; // Winning function of this pin.
			logic     segp; // LCD segment selected.
			// Priority decode of function registers, lowest first.
			// A pin with several function bits set behaves as the lowest one alone.
			always_comb begin
				if (cfg_a[p].function_select_1[b])      fn = PPFM_FN_F1;
				else if (cfg_a[p].function_select_2[b]) fn = PPFM_FN_F2;
				else if (cfg_a[p].function_select_3[b]) fn = PPFM_FN_F3;
				else                                    fn = PPFM_FN_GPIO;
				segp = (p <= 4) && (fn == PPFM_FN_F1)
					&& !cfg_a[p].output_control_bits[b] && !cfg_a[p].open_drain_bits[b]
					&& !cfg_a[p].pull_up_bits[b] && !cfg_a[p].pull_down_bits[b]
					&& !cfg_a[p].input_enable_bits[b];
			end
			// Pad drive: segment, peripheral, or port data per function.
			// Pulls and input enable pass straight through; only the drive
			// path depends on the chosen function.
			always_comb begin
				pad_nxt[p].pull_up[b]   = cfg_a[p].pull_up_bits[b];
				pad_nxt[p].pull_down[b] = cfg_a[p].pull_down_bits[b];
				pad_nxt[p].in_en[b]     = cfg_a[p].input_enable_bits[b];
				in_nxt[p][b] = pad_in[p*8+b] & cfg_a[p].input_enable_bits[b];
				if (segp) begin
					pad_nxt[p].out[b] = lcd_segment_out[(p*8+b) % 40];
					pad_nxt[p].oe[b]  = 1'b1;
				end else if (fn == PPFM_FN_GPIO) begin
					// Control 1 drives port data, control 0 floats.
					pad_nxt[p].out[b] = port_data[p*8+b];
					pad_nxt[p].oe[b]  = cfg_a[p].output_control_bits[b];
				end else begin
					// Peripheral output needs control 1; input-only use leaves it 0.
					pad_nxt[p].out[b] = periph_out[p*8+b];
					pad_nxt[p].oe[b]  = cfg_a[p].output_control_bits[b]
						& periph_oe[p*8+b];
				end
				// Open drain: only a low level is driven.
				// A segment driver is push-pull by nature, so open drain skips it.
				if (cfg_a[p].open_drain_bits[b] && !segp) begin
					pad_nxt[p].oe[b]  = pad_nxt[p].oe[b] & ~pad_nxt[p].out[b];
					pad_nxt[p].out[b] = 1'b0;
				end
			end
			assign out_flat[p*8+b] = pad_nxt[p].out[b];
			assign oe_flat[p*8+b]  = pad_nxt[p].oe[b];
			assign pu_flat[p*8+b]  = pad_nxt[p].pull_up[b];
			assign pd_flat[p*8+b]  = pad_nxt[p].pull_down[b];
			assign in_flat[p*8+b]  = in_nxt[p][b];
			assign pin_flat[p*8+b] = in_nxt[p][b] & (fn != PPFM_FN_GPIO);
		end
	end

	// Dedicated input routing: interrupts, analog, low-voltage, timer inputs.
	always_comb begin
		// Interrupts pass on input enable alone, outside stop mode.
		// The function bits are ignored on purpose: software must clear the
		// input enable of an unused interrupt pin, or stray edges reach the core.
		// The pins are fixed: F1, J2, G0 and K0 carry interrupts 0 to 3.
		irq_nxt[0] = !stop_mode && in_flat[5*8+1];
		irq_nxt[1] = !stop_mode && in_flat[9*8+2];
		irq_nxt[2] = !stop_mode && in_flat[6*8+0];
		irq_nxt[3] = !stop_mode && in_flat[10*8+0];
		// Analog and detect paths open while the pin's control, function-one, drain, pull and input-enable bits are all 0.
		for (int i = 0; i < 2; i++) begin
			ain_nxt[i] = (cfg_a[5] == '0) ||
				!(cfg_a[5].output_control_bits[i] | cfg_a[5].function_select_1[i]
				| cfg_a[5].open_drain_bits[i] | cfg_a[5].pull_up_bits[i]
				| cfg_a[5].pull_down_bits[i] | cfg_a[5].input_enable_bits[i]);
			lvd_nxt[i] = !(cfg_a[10].output_control_bits[i]
				| cfg_a[10].function_select_1[i] | cfg_a[10].open_drain_bits[i]
				| cfg_a[10].pull_up_bits[i] | cfg_a[10].pull_down_bits[i]
				| cfg_a[10].input_enable_bits[i]);
		end
		// Port J bit 5: capture via function one, clock via function two.
		cap_nxt  = in_flat[9*8+5] & cfg_a[9].function_select_1[5];
		xclk_nxt = in_flat[9*8+5] & !cfg_a[9].function_select_1[5]
			& cfg_a[9].function_select_2[5];
		// Readback of the addressed setting, zero for absent bits.
		// Absent bits read 0 because writes store 0 there; port E reset sets absent FR2 bits 0 and 1, which read 1 until written.
		rd_nxt = 8'h00;
		for (int q = 0; q < NP; q++) begin
			if (cfg_rd_port == 4'(q)) begin
				case (cfg_rd_sel)
					`PPFM_SEL_CR:  rd_nxt = cfg_a[q].output_control_bits;
					`PPFM_SEL_FR1: rd_nxt = cfg_a[q].function_select_1;
					`PPFM_SEL_FR2: rd_nxt = cfg_a[q].function_select_2;
					`PPFM_SEL_FR3: rd_nxt = cfg_a[q].function_select_3;
					`PPFM_SEL_OD:  rd_nxt = cfg_a[q].open_drain_bits;
					`PPFM_SEL_PUP: rd_nxt = cfg_a[q].pull_up_bits;
					`PPFM_SEL_PDN: rd_nxt = cfg_a[q].pull_down_bits;
					`PPFM_SEL_IE:  rd_nxt = cfg_a[q].input_enable_bits;
					default:       rd_nxt = 8'h00;
				endcase
			end
		end
	end

	// All outputs registered; reset leaves pads undriven and all pulls off until the first edge after reset.
	// The register stage costs one cycle but keeps every output glitch-free
	// while several setting bits change on the same edge.
	// Analog and detect flags reset high: those pins work before any write.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rd_data           <= 8'h00;
			pad_out               <= '0;
			pad_oe                <= '0;
			pad_pull_up           <= '0;
			pad_pull_down         <= '0;
			port_in               <= '0;
			periph_in             <= '0;
			analog_input          <= 2'h3;
			low_voltage_detect_in <= 2'h3;
			ext_interrupt_in      <= 4'h0;
			timer_capture_in      <= 1'b0;
			external_clock_in     <= 1'b0;
		end else begin
			cfg_rd_data           <= rd_nxt;
			pad_out               <= out_flat;
			pad_oe                <= oe_flat;
			pad_pull_up           <= pu_flat;
			pad_pull_down         <= pd_flat;
			port_in               <= in_flat;
			periph_in             <= pin_flat;
			analog_input          <= ain_nxt;
			low_voltage_detect_in <= lvd_nxt;
			ext_interrupt_in      <= irq_nxt;
			timer_capture_in      <= cap_nxt;
			external_clock_in     <= xclk_nxt;
		end
	end
endmodule // ppfm_top
`default_nettype wire

/* File: testbench/ppfm_checker.sv */
// Concurrent checks on the pin function multiplexer top ports.
// Assumes binding onto ppfm_top, one clock domain, async active-low reset.
`default_nettype none
module ppfm_checker
	import ppfm_pkg::*;
#(
	parameter int NUM_PORTS = 11
) (
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	input wire logic                   stop_mode,
	input wire logic [3:0]             cfg_rd_port,
	input wire logic [7:0]             cfg_rd_data,
	input wire logic [NUM_PORTS*8-1:0] pad_in,
	input wire logic [NUM_PORTS*8-1:0] pad_oe,
	input wire logic [NUM_PORTS*8-1:0] pad_pull_up,
	input wire logic [NUM_PORTS*8-1:0] pad_pull_down,
	input wire logic [NUM_PORTS*8-1:0] port_in,
	input wire logic [NUM_PORTS*8-1:0] periph_in,
	input wire logic [1:0]             analog_input,
	input wire logic [1:0]             low_voltage_detect_in,
	input wire logic [3:0]             ext_interrupt_in,
	input wire logic                   timer_capture_in,
	input wire logic                   external_clock_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// All checks share the system clock and its reset.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_rst_val;
		!$past(rst_n) |-> analog_input == 2'h3 && low_voltage_detect_in == 2'h3 && pad_oe == '0;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset levels wrong");
	property p_dbg;
		!$past(rst_n) |=> pad_pull_down[38] && pad_pull_up[39] && !pad_oe[38];
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug pins not set");
	property p_int_src;
		ext_interrupt_in[0] |-> $past(pad_in[41]) && !$past(stop_mode);
	endproperty
	a_int_src: assert property (p_int_src) else $error("interrupt without cause");
	property p_stop;
		$past(stop_mode) |-> ext_interrupt_in == 4'h0;
	endproperty
	a_stop: assert property (p_stop) else $error("interrupt in stop");
	property p_in_gate;
		((port_in | periph_in) & ~$past(pad_in)) == '0;
	endproperty
	a_in_gate: assert property (p_in_gate) else $error("input not from pad");
	property p_j5;
		timer_capture_in || external_clock_in |-> $past(pad_in[77]) && !(timer_capture_in && external_clock_in);
	endproperty
	a_j5: assert property (p_j5) else $error("capture pin routing wrong");
	property p_j5_in;
		!(pad_oe[77] || pad_pull_up[77] || pad_pull_down[77]);
	endproperty
	a_j5_in: assert property (p_j5_in) else $error("input pin driven");
	property p_analog;
		analog_input[1] |-> !(pad_oe[41] || pad_pull_up[41] || pad_pull_down[41] || periph_in[41]);
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin disturbed");
	property p_lvd;
		low_voltage_detect_in[0] |-> !(pad_oe[80] || ext_interrupt_in[3]);
	endproperty
	a_lvd: assert property (p_lvd) else $error("detect pin disturbed");
	property p_absent;
		$past(cfg_rd_port) == 4'h5 |-> cfg_rd_data[7:2] == 6'h0 && pad_oe[47:42] == 6'h0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent bits not zero");
endmodule // ppfm_checker
bind ppfm_top ppfm_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_sys, .rst_n, .stop_mode,
	.cfg_rd_port, .cfg_rd_data, .pad_in, .pad_oe, .pad_pull_up, .pad_pull_down, .port_in,
	.periph_in, .analog_input, .low_voltage_detect_in, .ext_interrupt_in, .timer_capture_in,
	.external_clock_in);
`default_nettype wire

/* File: testbench/ppfm_pad_model.sv */
// Pad wires outside the block: drivers, pulls and external sources.
// Assumes the bench chooses which pins an outside source drives.
`default_nettype none
module ppfm_pad_model
(
	input  wire logic        clk_sys,
	input  wire logic [87:0] pad_out,
	input  wire logic [87:0] pad_oe,
	input  wire logic [87:0] pad_pull_up,
	input  wire logic [87:0] pad_pull_down,
	input  wire logic [87:0] ext_drv,
	input  wire logic [87:0] ext_lvl,
	output logic      [87:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flt_r = 1'b0; // Level of a floating pad, toggled so it never looks stable.
	// A floating pad wanders every cycle instead of holding its last value.
	always @(posedge clk_sys) begin
		flt_r <= ~flt_r;
	end
	// Block drive wins, then an outside source, then pulls.
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_lvl)
		| (~pad_oe & ~ext_drv & (pad_pull_up | (~pad_pull_down & {88{flt_r}})));
endmodule // ppfm_pad_model
`default_nettype wire

/* File: testbench/port_pin_function_mux_bench.sv */
// Self-checking bench for the pin function multiplexer.
// Assumes ppfm_top, the pad model and the bound checker.
`default_nettype none
module port_pin_function_mux_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst_n, cfg_wr_en, stop_mode, timer_capture_in, external_clock_in;
	logic [3:0]  cfg_wr_port, cfg_rd_port, ext_interrupt_in;
	logic [2:0]  cfg_wr_sel, cfg_rd_sel;
	logic [7:0]  cfg_wr_data, cfg_rd_data;
	logic [87:0] port_data, periph_out, periph_oe, pad_in, pad_out, pad_oe, ext_drv, ext_lvl;
	logic [87:0] pad_pull_up, pad_pull_down, port_in, periph_in;
	logic [39:0] lcd_segment_out;
	logic [1:0]  analog_input, low_voltage_detect_in;
	int          failures, cmp_count;
	ppfm_top u_dut (.clk_sys, .rst_n, .cfg_wr_en, .cfg_wr_port, .cfg_wr_sel, .cfg_wr_data,
		.cfg_rd_port, .cfg_rd_sel, .stop_mode, .port_data, .periph_out, .periph_oe,
		.lcd_segment_out, .pad_in, .cfg_rd_data, .pad_out, .pad_oe, .pad_pull_up,
		.pad_pull_down, .port_in, .periph_in, .analog_input, .low_voltage_detect_in,
		.ext_interrupt_in, .timer_capture_in, .external_clock_in);
	ppfm_pad_model u_pad (.clk_sys, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
		.ext_drv, .ext_lvl, .pad_in);
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [87:0] got, input logic [87:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Presents one write; the strobe stays high so back-to-back writes never glitch it.
	task automatic wr(input logic [3:0] p, input logic [2:0] s, input logic [7:0] d);
		cfg_wr_port = p;
		cfg_wr_sel = s;
		cfg_wr_data = d;
		cfg_wr_en = 1'b1;
		@(negedge clk_sys);
	endtask
	// Ends a write burst and waits the two edges until outputs follow.
	task automatic settle();
		cfg_wr_en = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	// Reads one setting back after its one-cycle latency.
	task automatic rd(input logic [3:0] p, input logic [2:0] s, input logic [7:0] exp);
		cfg_rd_port = p;
		cfg_rd_sel = s;
		@(negedge clk_sys);
		chk(cfg_rd_data, exp);
	endtask
	// Reset state: port E debug pins set, analog and detect pins free.
	task automatic t_reset();
		rd(4'h4, 3'h7, 8'hc3);
		rd(4'h4, 3'h0, 8'h82);
		rd(4'h4, 3'h5, 8'h82);
		rd(4'h4, 3'h6, 8'h41);
		rd(4'h4, 3'h2, 8'hc3);
		rd(4'h0, 3'h0, 8'h00);
		chk(pad_oe[31:0], 32'h0);
		chk({pad_pull_up[39], pad_pull_down[38]}, 2'h3);
		chk({analog_input, low_voltage_detect_in}, 4'hf);
	endtask
	// Segment drive on port A, then plain output and input on port B.
	task automatic t_lcd_gpio();
		wr(4'h0, 3'h1, 8'hff);
		wr(4'h1, 3'h0, 8'hff);
		settle();
		chk(pad_oe[7:0], 8'hff);
		chk(pad_out[7:0], 8'h5a);
		chk(pad_out[15:8], 8'ha5);
		wr(4'h1, 3'h0, 8'h00);
		wr(4'h1, 3'h7, 8'hff);
		settle();
		chk(pad_oe[15:8], 8'h00);
		chk(port_in[15:8], 8'h3c);
	endtask
	// Absent bits are dropped on write and read as zero.
	task automatic t_mask();
		wr(4'h5, 3'h0, 8'hff);
		wr(4'h9, 3'h0, 8'hff);
		wr(4'h4, 3'h2, 8'hff);
		wr(4'h5, 3'h2, 8'hff);
		settle();
		rd(4'h5, 3'h0, 8'h03);
		rd(4'h9, 3'h0, 8'h1f);
		rd(4'h4, 3'h2, 8'hfc);
		rd(4'h5, 3'h2, 8'h00);
		wr(4'h5, 3'h0, 8'h00);
		wr(4'h9, 3'h0, 8'h00);
		settle();
	endtask
	// Port F interrupt, stop mode, and the analog flags around it.
	task automatic t_int();
		wr(4'h5, 3'h7, 8'h02);
		wr(4'h5, 3'h1, 8'h02);
		settle();
		chk(ext_interrupt_in[0], 1'b1);
		chk(analog_input, 2'h1);
		stop_mode = 1'b1;
		settle();
		chk(ext_interrupt_in[0], 1'b0);
		stop_mode = 1'b0;
		wr(4'h5, 3'h1, 8'h00);
		settle();
		chk(ext_interrupt_in[0], 1'b1);
		wr(4'h5, 3'h7, 8'h00);
		settle();
		chk(analog_input, 2'h3);
	endtask
	// Capture pin with both functions set, then the clock function alone.
	task automatic t_j5();
		wr(4'h9, 3'h7, 8'h20);
		wr(4'h9, 3'h1, 8'h20);
		wr(4'h9, 3'h2, 8'h20);
		settle();
		chk({timer_capture_in, external_clock_in}, 2'h2);
		wr(4'h9, 3'h1, 8'h00);
		settle();
		chk({timer_capture_in, external_clock_in}, 2'h1);
	endtask
	// Open-drain peripheral pin on port J, then port G output and interrupt uses.
	task automatic t_od_g0();
		wr(4'h9, 3'h0, 8'h01);
		wr(4'h9, 3'h4, 8'h01);
		wr(4'h9, 3'h5, 8'h01);
		wr(4'h9, 3'h7, 8'h01);
		wr(4'h9, 3'h1, 8'h01);
		wr(4'h6, 3'h0, 8'h01);
		wr(4'h6, 3'h1, 8'h01);
		wr(4'h6, 3'h2, 8'h01);
		settle();
		chk({pad_oe[72], pad_out[72]}, 2'h2);
		chk({pad_oe[48], pad_out[48]}, 2'h3);
		periph_out[72] = 1'b1;
		settle();
		chk({pad_oe[72], periph_in[72]}, 2'h1);
		wr(4'h6, 3'h0, 8'h00);
		wr(4'h6, 3'h1, 8'h00);
		wr(4'h6, 3'h7, 8'h01);
		settle();
		chk({pad_oe[48], ext_interrupt_in[2]}, 2'h1);
	endtask
	// Third function on port H, port K interrupt, J2 interrupt by enable alone.
	task automatic t_fr3_k();
		periph_oe[58] = 1'b1;
		periph_out[58] = 1'b1;
		wr(4'h7, 3'h3, 8'h04);
		wr(4'h7, 3'h0, 8'h04);
		wr(4'ha, 3'h7, 8'h01);
		wr(4'ha, 3'h1, 8'h01);
		wr(4'h9, 3'h7, 8'h05);
		settle();
		chk({pad_oe[58], pad_out[58]}, 2'h3);
		chk(ext_interrupt_in, 4'he);
		chk(low_voltage_detect_in, 2'h2);
	endtask
	// Reset in mid-run brings every setting back, the port E debug pins too.
	task automatic t_rerst();
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		rd(4'h4, 3'h2, 8'hc3);
		rd(4'ha, 3'h7, 8'h00);
		chk({analog_input, low_voltage_detect_in}, 4'hf);
		chk(pad_oe[63:56], 8'h00);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Cuts a hang short; the tests need under 100 cycles of the 2500 allowed.
	initial begin
		#100us;
		failures++;
		stop_test();
	end
	initial begin
		{rst_n, cfg_wr_en, stop_mode, cfg_wr_port, cfg_rd_port, cfg_wr_sel, cfg_rd_sel} = '0;
		{cfg_wr_data, periph_out, periph_oe, failures, cmp_count} = '0;
		port_data = 88'ha5_00;
		lcd_segment_out = 40'h5a;
		ext_drv = 88'h01_24_00_00_01_02_00_00_00_ff_00;
		ext_lvl = 88'h01_24_00_00_01_02_00_00_00_3c_00;
		periph_oe[72] = 1'b1;
		periph_oe[48] = 1'b1;
		periph_out[48] = 1'b1;
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_lcd_gpio();
		t_mask();
		t_int();
		t_j5();
		t_od_g0();
		t_fr3_k();
		t_rerst();
		stop_test();
	end
endmodule // port_pin_function_mux_bench
`default_nettype wire
